/* cbu_pkg.sv */
/*
 * Constants for the capacitor-bank neutral unbalance alarm/trip stage:
 * register offsets, field positions, reset values, scaling and timing.
 * Assumes a 100 MHz clock and a 5 ms processing tick.
 */
package cbu_pkg;

   // currents and thresholds in 0.01 x nominal, amperes in 0.01 A
   localparam int CUR_W   = 13;
   localparam int FUSE_W  = 6;
   localparam int DLY_W   = 19;              // 5 ms steps, 0..360000
   localparam int RATIO_W = 17;              // 0.01 steps, 0..125000
   localparam int PROD_W  = 20;

   localparam logic [RATIO_W-1:0] RATIO_MAX = 17'h1E848;   // 1250.00
   localparam logic [PROD_W-1:0]  PCT_FULL  = 20'h00064;   // 100 %
   localparam logic [PROD_W-1:0]  PCT_RESET = 20'h00061;   // 97 %

   localparam logic [CUR_W-1:0]  CUR_THR_MIN  = 13'h000A;  // 0.10 x In
   localparam logic [CUR_W-1:0]  CUR_THR_MAX  = 13'h1388;  // 50.00 x In
   localparam logic [FUSE_W-1:0] FUSE_THR_MIN = 6'h01;
   localparam logic [FUSE_W-1:0] FUSE_THR_MAX = 6'h32;     // 50 fuses
   localparam logic [DLY_W-1:0]  DLY_MAX      = 19'h57E40; // 1800 s

   localparam logic [CUR_W-1:0]  RST_ALM_THR  = 13'h000A;  // 0.1 x In
   localparam logic [CUR_W-1:0]  RST_TRP_THR  = 13'h0014;  // 0.2 x In
   localparam logic [FUSE_W-1:0] RST_FUSE_ALM = 6'h03;
   localparam logic [FUSE_W-1:0] RST_FUSE_TRP = 6'h05;
   localparam logic [DLY_W-1:0]  RST_DLY      = 19'h003E8; // 5 s

   // timing: tick period in ns and its cycle count
   localparam int CLK_NS  = 10;
   localparam int TICK_NS = 5000000;
   localparam int TICK_CYC_DEF = (TICK_NS + CLK_NS - 1) / CLK_NS;

   // register byte addresses
   localparam logic [7:0] A_CTRL      = 8'h00;
   localparam logic [7:0] A_ALM_THR   = 8'h04;
   localparam logic [7:0] A_ALM_THR2  = 8'h08;
   localparam logic [7:0] A_TRP_THR   = 8'h0C;
   localparam logic [7:0] A_TRP_THR2  = 8'h10;
   localparam logic [7:0] A_FUSE_THR  = 8'h14;
   localparam logic [7:0] A_ALM_DLY   = 8'h18;
   localparam logic [7:0] A_ALM_DLY2  = 8'h1C;
   localparam logic [7:0] A_TRP_DLY   = 8'h20;
   localparam logic [7:0] A_STATUS    = 8'h24;
   localparam logic [7:0] A_ALM_REM   = 8'h28;
   localparam logic [7:0] A_TRP_REM   = 8'h2C;
   localparam logic [7:0] A_EXP_ALM   = 8'h30;
   localparam logic [7:0] A_RATIO_ALM = 8'h34;
   localparam logic [7:0] A_RATIO_TRP = 8'h38;
   localparam logic [7:0] A_MEAS_AMP  = 8'h3C;
   localparam logic [7:0] A_IRQ_STAT  = 8'h40;
   localparam logic [7:0] A_IRQ_MASK  = 8'h44;

   // control bits
   localparam int C_ENABLE = 0;
   localparam int C_DIFFER = 1;
   localparam int C_FUSE   = 2;
   localparam int C_BLOCK  = 3;
   localparam logic [3:0] RST_CTRL = 4'h1;

   // fuse threshold field positions
   localparam int F_ALM  = 0;
   localparam int F_ALM2 = 8;
   localparam int F_TRP  = 16;
   localparam int F_TRP2 = 24;

   // status fields
   localparam int S_ALARM = 2;
   localparam int S_TRIP  = 3;

   // interrupt event bits
   localparam int E_ALM_START = 0;
   localparam int E_ALARM     = 1;
   localparam int E_TRP_START = 2;
   localparam int E_TRIP      = 3;
   localparam int E_BLOCKED   = 4;
   localparam int EV_W        = 5;

   typedef enum logic [1:0] {
      ST_NORMAL,
      ST_STARTED,
      ST_TRIPPED,
      ST_BLOCKED
   } cbu_state_t;

endpackage : cbu_pkg

/* cbu_dt_timer.sv */
/*
 * Definite-time delay counter in 5 ms tick steps.
 * Assumes i_tick is a one-cycle enable and i_dly is stable while running.
 */
module cbu_dt_timer
   import cbu_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_nrst,
   input  wire logic             i_tick,
   input  wire logic             i_pick,
   input  wire logic [DLY_W-1:0] i_dly,
   output logic                  o_done,
   output logic [DLY_W-1:0]      o_rem
);
   import cbu_pkg::*;

   typedef struct packed {
      logic [DLY_W-1:0] cnt;
      logic             done;
   } cbu_tmr_t;

   cbu_tmr_t s_r;
   cbu_tmr_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (!i_pick)
      begin
         s_nxt.cnt  = '0;
         s_nxt.done = 1'b0;
      end
      else if (s_r.cnt >= i_dly)
         s_nxt.done = 1'b1;
      else if (i_tick)
         s_nxt.cnt = s_r.cnt + 1'b1;
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign o_done = s_r.done;
   // saturates at zero: a delay lowered mid-run must not wrap
   assign o_rem  = (s_r.cnt >= i_dly) ? '0 : i_dly - s_r.cnt;

endmodule : cbu_dt_timer

/* cbu_stage.sv */
/*
 * Alarm and trip decision stage of a capacitor-bank neutral unbalance
 * protection: thresholds, hysteresis, definite-time delays, status,
 * remaining times, ratios, register port and interrupt.
 * Assumes the measurement front end runs on i_clk and presents a sample
 * with i_meas_valid; settings are written by software over the port.
 */
module cbu_stage
   import cbu_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYC_DEF
)
(
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic [7:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   input  wire logic              i_meas_valid,
   input  wire logic [CUR_W-1:0]  i_unb_pu,
   input  wire logic [CUR_W-1:0]  i_unb_amp,
   input  wire logic              i_unb_side,
   input  wire logic [FUSE_W-1:0] i_fuse_cnt_1,
   input  wire logic [FUSE_W-1:0] i_fuse_cnt_2,
   output logic [31:0]            o_rdata,
   output logic                   o_start,
   output logic                   o_alarm,
   output logic                   o_trip,
   output logic [1:0]             o_state,
   output logic                   o_irq
);
   import cbu_pkg::*;

   if (TICK_CYC < 1)
      $error("TICK_CYC must be at least 1");

   typedef struct packed {
      logic [3:0]          ctrl;
      logic [CUR_W-1:0]    alm_thr;
      logic [CUR_W-1:0]    alm_thr2;
      logic [CUR_W-1:0]    trp_thr;
      logic [CUR_W-1:0]    trp_thr2;
      logic [FUSE_W-1:0]   f_alm;
      logic [FUSE_W-1:0]   f_alm2;
      logic [FUSE_W-1:0]   f_trp;
      logic [FUSE_W-1:0]   f_trp2;
      logic [DLY_W-1:0]    alm_dly;
      logic [DLY_W-1:0]    alm_dly2;
      logic [DLY_W-1:0]    trp_dly;
      logic [31:0]         div;
      logic                tick;
      logic [CUR_W-1:0]    meas;
      logic [CUR_W-1:0]    amp;
      logic                side;
      logic [FUSE_W-1:0]   fc1;
      logic [FUSE_W-1:0]   fc2;
      logic [CUR_W-1:0]    peak;
      logic [3:0]          held;   // alm1, alm2, trp1, trp2 current pick-ups
      cbu_state_t          state;
      logic                start;
      logic                alarm;
      logic                trip;
      logic [EV_W-1:0]     ev_stat;
      logic [EV_W-1:0]     ev_mask;
      logic                irq;
      logic [31:0]         rdata;
   } cbu_st_t;

   cbu_st_t s_r;
   cbu_st_t s_nxt;

   logic             pick_a1;
   logic             pick_a2;
   logic             pick_t;
   logic             done_a1;
   logic             done_a2;
   logic             done_t;
   logic [DLY_W-1:0] rem_a1;
   logic [DLY_W-1:0] rem_a2;
   logic [DLY_W-1:0] rem_t;

   // pick-up with fixed release hysteresis relative to the set value
   function automatic logic over(input logic [CUR_W-1:0] m,
                                 input logic [CUR_W-1:0] t,
                                 input logic             held);
      logic [PROD_W-1:0] mp;
      mp = PROD_W'(m) * PCT_FULL;
      if (held)
         over = mp >= PROD_W'(t) * PCT_RESET;
      else
         over = m > t;
   endfunction : over

   function automatic logic [RATIO_W-1:0] ratio(input logic [CUR_W-1:0] m,
                                                input logic [CUR_W-1:0] t);
      logic [PROD_W-1:0] q;
      q = '0;
      if (t != '0)
         q = (PROD_W'(m) * PCT_FULL) / PROD_W'(t);
      ratio = (q > PROD_W'(RATIO_MAX)) ? RATIO_MAX : q[RATIO_W-1:0];
   endfunction : ratio

   function automatic logic [CUR_W-1:0] clamp_cur(input logic [31:0] d);
      if (d < 32'(CUR_THR_MIN))
         clamp_cur = CUR_THR_MIN;
      else if (d > 32'(CUR_THR_MAX))
         clamp_cur = CUR_THR_MAX;
      else
         clamp_cur = d[CUR_W-1:0];
   endfunction : clamp_cur

   function automatic logic [FUSE_W-1:0] clamp_fuse(input logic [7:0] d);
      if (d < 8'(FUSE_THR_MIN))
         clamp_fuse = FUSE_THR_MIN;
      else if (d > 8'(FUSE_THR_MAX))
         clamp_fuse = FUSE_THR_MAX;
      else
         clamp_fuse = d[FUSE_W-1:0];
   endfunction : clamp_fuse

   function automatic logic [DLY_W-1:0] clamp_dly(input logic [31:0] d);
      clamp_dly = (d > 32'(DLY_MAX)) ? DLY_MAX : d[DLY_W-1:0];
   endfunction : clamp_dly

   // effective side 2 settings and pick-up terms
   logic             differ;
   logic             fuse_on;
   logic             active;
   logic [CUR_W-1:0] m1;
   logic [CUR_W-1:0] m2;
   logic [CUR_W-1:0] ea2;
   logic [CUR_W-1:0] et2;
   logic [FUSE_W-1:0] efa2;
   logic [FUSE_W-1:0] eft2;
   logic [DLY_W-1:0] edly2;
   logic [3:0]       held_c;

   always_comb
   begin
      differ  = s_r.ctrl[C_DIFFER];
      fuse_on = s_r.ctrl[C_FUSE];
      active  = s_r.ctrl[C_ENABLE] & ~s_r.ctrl[C_BLOCK];
      m1      = s_r.side ? '0 : s_r.meas;
      m2      = s_r.side ? s_r.meas : '0;
      ea2     = differ ? s_r.alm_thr2 : s_r.alm_thr;
      et2     = differ ? s_r.trp_thr2 : s_r.trp_thr;
      efa2    = differ ? s_r.f_alm2 : s_r.f_alm;
      eft2    = differ ? s_r.f_trp2 : s_r.f_trp;
      edly2   = differ ? s_r.alm_dly2 : s_r.alm_dly;
      held_c[0] = over(m1, s_r.alm_thr, s_r.held[0]);
      held_c[1] = over(m2, ea2, s_r.held[1]);
      held_c[2] = over(m1, s_r.trp_thr, s_r.held[2]);
      held_c[3] = over(m2, et2, s_r.held[3]);
      pick_a1 = active & (s_r.held[0] | (fuse_on & (s_r.fc1 >= s_r.f_alm)));
      pick_a2 = active & (s_r.held[1] | (fuse_on & (s_r.fc2 >= efa2)));
      pick_t  = active & (s_r.held[2] | s_r.held[3] |
                          (fuse_on & ((s_r.fc1 >= s_r.f_trp) | (s_r.fc2 >= eft2))));
   end

   cbu_dt_timer u_alm1 (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_tick (s_r.tick),
      .i_pick (pick_a1),
      .i_dly  (s_r.alm_dly),
      .o_done (done_a1),
      .o_rem  (rem_a1)
   );

   cbu_dt_timer u_alm2 (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_tick (s_r.tick),
      .i_pick (pick_a2),
      .i_dly  (edly2),
      .o_done (done_a2),
      .o_rem  (rem_a2)
   );

   cbu_dt_timer u_trip (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_tick (s_r.tick),
      .i_pick (pick_t),
      .i_dly  (s_r.trp_dly),
      .o_done (done_t),
      .o_rem  (rem_t)
   );

   // live values shown to software
   logic [DLY_W-1:0]   alm_rem;
   logic [DLY_W:0]     exp_alm;
   logic [CUR_W-1:0]   alm_ref;
   logic [CUR_W-1:0]   trp_ref;
   logic [EV_W-1:0]    ev;
   logic               any_alm;

   always_comb
   begin
      any_alm = pick_a1 | pick_a2;
      alm_rem = pick_a1 ? rem_a1 : (pick_a2 ? rem_a2 : '0);
      // signed; idle shows the full delay of the measured side
      exp_alm = any_alm ? {1'b0, alm_rem} :
                {1'b0, (s_r.side ? edly2 : s_r.alm_dly)};
      alm_ref = s_r.side ? ea2 : s_r.alm_thr;
      trp_ref = s_r.side ? et2 : s_r.trp_thr;
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.held = held_c;
      // tick divider
      s_nxt.tick = 1'b0;
      if (s_r.div >= 32'(TICK_CYC - 1))
      begin
         s_nxt.div  = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.div = s_r.div + 32'h1;

      if (i_meas_valid)
      begin
         s_nxt.meas = i_unb_pu;
         s_nxt.amp  = i_unb_amp;
         s_nxt.side = i_unb_side;
         s_nxt.fc1  = i_fuse_cnt_1;
         s_nxt.fc2  = i_fuse_cnt_2;
      end
      // highest unbalance held while the alarm is timing
      if (!any_alm)
         s_nxt.peak = s_r.meas;
      else if (s_r.meas > s_r.peak)
         s_nxt.peak = s_r.meas;

      s_nxt.start = any_alm | pick_t;
      s_nxt.alarm = done_a1 | done_a2;
      s_nxt.trip  = done_t;
      if (s_r.ctrl[C_ENABLE] & s_r.ctrl[C_BLOCK])
         s_nxt.state = ST_BLOCKED;
      else if (done_t)
         s_nxt.state = ST_TRIPPED;
      else if (any_alm | pick_t)
         s_nxt.state = ST_STARTED;
      else
         s_nxt.state = ST_NORMAL;

      // register writes
      if (i_wr)
      begin
         case (i_addr)
            A_CTRL:     s_nxt.ctrl     = i_wdata[3:0];
            A_ALM_THR:  s_nxt.alm_thr  = clamp_cur(i_wdata);
            A_ALM_THR2: s_nxt.alm_thr2 = clamp_cur(i_wdata);
            A_TRP_THR:  s_nxt.trp_thr  = clamp_cur(i_wdata);
            A_TRP_THR2: s_nxt.trp_thr2 = clamp_cur(i_wdata);
            A_FUSE_THR:
            begin
               s_nxt.f_alm  = clamp_fuse(i_wdata[F_ALM+:8]);
               s_nxt.f_alm2 = clamp_fuse(i_wdata[F_ALM2+:8]);
               s_nxt.f_trp  = clamp_fuse(i_wdata[F_TRP+:8]);
               s_nxt.f_trp2 = clamp_fuse(i_wdata[F_TRP2+:8]);
            end
            A_ALM_DLY:  s_nxt.alm_dly  = clamp_dly(i_wdata);
            A_ALM_DLY2: s_nxt.alm_dly2 = clamp_dly(i_wdata);
            A_TRP_DLY:  s_nxt.trp_dly  = clamp_dly(i_wdata);
            A_IRQ_MASK: s_nxt.ev_mask  = i_wdata[EV_W-1:0];
            default:    s_nxt.ctrl     = s_r.ctrl;
         endcase
      end

      // register reads, data valid the cycle after the strobe
      s_nxt.rdata = '0;
      if (i_rd)
      begin
         case (i_addr)
            A_CTRL:      s_nxt.rdata = 32'(s_r.ctrl);
            A_ALM_THR:   s_nxt.rdata = 32'(s_r.alm_thr);
            A_ALM_THR2:  s_nxt.rdata = 32'(s_r.alm_thr2);
            A_TRP_THR:   s_nxt.rdata = 32'(s_r.trp_thr);
            A_TRP_THR2:  s_nxt.rdata = 32'(s_r.trp_thr2);
            A_FUSE_THR:  s_nxt.rdata = {2'h0, s_r.f_trp2, 2'h0, s_r.f_trp,
                                        2'h0, s_r.f_alm2, 2'h0, s_r.f_alm};
            A_ALM_DLY:   s_nxt.rdata = 32'(s_r.alm_dly);
            A_ALM_DLY2:  s_nxt.rdata = 32'(s_r.alm_dly2);
            A_TRP_DLY:   s_nxt.rdata = 32'(s_r.trp_dly);
            A_STATUS:    s_nxt.rdata = 32'({s_r.trip, s_r.alarm, s_r.state});
            A_ALM_REM:   s_nxt.rdata = 32'(alm_rem);
            A_TRP_REM:   s_nxt.rdata = 32'(pick_t ? rem_t : '0);
            A_EXP_ALM:   s_nxt.rdata = {{(31-DLY_W){exp_alm[DLY_W]}}, exp_alm};
            A_RATIO_ALM: s_nxt.rdata = 32'(ratio(s_r.peak, alm_ref));
            A_RATIO_TRP: s_nxt.rdata = 32'(ratio(s_r.meas, trp_ref));
            A_MEAS_AMP:  s_nxt.rdata = 32'(s_r.amp);
            A_IRQ_STAT:  s_nxt.rdata = 32'(s_r.ev_stat);
            A_IRQ_MASK:  s_nxt.rdata = 32'(s_r.ev_mask);
            default:     s_nxt.rdata = '0;
         endcase
      end

      // rising-edge events; a set in the clearing cycle survives
      ev = '0;
      ev[E_ALM_START] = any_alm & ~(s_r.start & ~pick_t);
      ev[E_ALM_START] = any_alm & (s_r.state == ST_NORMAL);
      ev[E_ALARM]     = s_nxt.alarm & ~s_r.alarm;
      ev[E_TRP_START] = pick_t & ~s_r.start;
      ev[E_TRIP]      = s_nxt.trip & ~s_r.trip;
      ev[E_BLOCKED]   = (s_nxt.state == ST_BLOCKED) & (s_r.state != ST_BLOCKED);
      if (i_rd && i_addr == A_IRQ_STAT)
         s_nxt.ev_stat = ev;
      else
         s_nxt.ev_stat = s_r.ev_stat | ev;
      s_nxt.irq = |(s_nxt.ev_stat & s_nxt.ev_mask);
   end

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_r          <= '0;
         s_r.ctrl     <= RST_CTRL;
         s_r.alm_thr  <= RST_ALM_THR;
         s_r.alm_thr2 <= RST_ALM_THR;
         s_r.trp_thr  <= RST_TRP_THR;
         s_r.trp_thr2 <= RST_TRP_THR;
         s_r.f_alm    <= RST_FUSE_ALM;
         s_r.f_alm2   <= RST_FUSE_ALM;
         s_r.f_trp    <= RST_FUSE_TRP;
         s_r.f_trp2   <= RST_FUSE_TRP;
         s_r.alm_dly  <= RST_DLY;
         s_r.alm_dly2 <= RST_DLY;
         s_r.trp_dly  <= RST_DLY;
         s_r.state    <= ST_NORMAL;
      end
      else
         s_r <= s_nxt;
   end

   assign o_rdata = s_r.rdata;
   assign o_start = s_r.start;
   assign o_alarm = s_r.alarm;
   assign o_trip  = s_r.trip;
   assign o_state = s_r.state;
   assign o_irq   = s_r.irq;

endmodule : cbu_stage

/* cbu_stage_props.sv */
/*
 * Checker for the unbalance stage, seeing only its top-level ports.
 * Assumes the register map and event bits of cbu_pkg; bound below.
 */
module cbu_stage_props
   import cbu_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_nrst,
   input wire logic [7:0]        i_addr,
   input wire logic [31:0]       i_wdata,
   input wire logic              i_wr,
   input wire logic              i_rd,
   input wire logic              i_meas_valid,
   input wire logic [CUR_W-1:0]  i_unb_pu,
   input wire logic [CUR_W-1:0]  i_unb_amp,
   input wire logic              i_unb_side,
   input wire logic [FUSE_W-1:0] i_fuse_cnt_1,
   input wire logic [FUSE_W-1:0] i_fuse_cnt_2,
   input wire logic [31:0]       o_rdata,
   input wire logic              o_start,
   input wire logic              o_alarm,
   input wire logic              o_trip,
   input wire logic [1:0]        o_state,
   input wire logic              o_irq
);
   import cbu_pkg::*;

   logic en_r;
   logic mask_zero_r;

   // shadow of the enable bit and mask, tracked from bus writes
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         en_r        <= 1'b1;
         mask_zero_r <= 1'b1;
      end
      else
      begin
         if (i_wr && i_addr == A_CTRL)
            en_r <= i_wdata[C_ENABLE];
         if (i_wr && i_addr == A_IRQ_MASK)
            mask_zero_r <= (i_wdata[EV_W-1:0] == 5'h00);
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_rdata_idle:     assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data not zero outside read answer");
   a_rdata_unmapped: assert property (i_rd && i_addr > A_IRQ_MASK |=> o_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_alarm_start:    assert property ($rose(o_alarm) |-> o_start)
      else $error("alarm without pick-up");
   a_trip_start:     assert property ($rose(o_trip) |-> o_start)
      else $error("trip without pick-up");
   a_trip_state:     assert property ($rose(o_trip) |-> ##[0:2] o_state == ST_TRIPPED)
      else $error("trip not reported as tripped");
   a_block_quiet:    assert property (o_state == ST_BLOCKED [*3] |-> !o_start && !o_trip)
      else $error("pick-up active while blocked");
   a_irq_masked:     assert property (mask_zero_r [*3] |-> !o_irq)
      else $error("interrupt with all events masked");
   a_disable_quiet:  assert property (!en_r [*4] |-> !o_start && o_state == ST_NORMAL)
      else $error("activity while disabled");
   a_start_state:    assert property (o_start [*3] |-> o_state != ST_NORMAL)
      else $error("pick-up reported as normal");

   c_alarm:   cover property ($rose(o_alarm));
   c_trip:    cover property ($rose(o_trip));
   c_blocked: cover property (o_state == ST_BLOCKED);
endmodule : cbu_stage_props

bind cbu_stage cbu_stage_props cbu_stage_props_i (.i_clk(i_clk), .i_nrst(i_nrst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_meas_valid(i_meas_valid),
   .i_unb_pu(i_unb_pu), .i_unb_amp(i_unb_amp), .i_unb_side(i_unb_side),
   .i_fuse_cnt_1(i_fuse_cnt_1), .i_fuse_cnt_2(i_fuse_cnt_2), .o_rdata(o_rdata),
   .o_start(o_start), .o_alarm(o_alarm), .o_trip(o_trip), .o_state(o_state), .o_irq(o_irq));

/* cbu_meas_model.sv */
/*
 * Measurement front end model: presents one unbalance sample per request.
 * Assumes requests come from the bench one cycle long on i_clk.
 */
module cbu_meas_model
   import cbu_pkg::*;
(
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic              i_send,
   input  wire logic [CUR_W-1:0]  i_pu,
   input  wire logic              i_side,
   input  wire logic [FUSE_W-1:0] i_fuse,
   output logic                   o_valid,
   output logic [CUR_W-1:0]       o_pu,
   output logic [CUR_W-1:0]       o_amp,
   output logic                   o_side,
   output logic [FUSE_W-1:0]      o_fuse_1,
   output logic [FUSE_W-1:0]      o_fuse_2
);
   timeunit 1ns;
   timeprecision 1ps;
   // values hold until the next sample, as a real front end does
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_valid  <= 1'b0;
         o_pu     <= '0;
         o_amp    <= '0;
         o_side   <= 1'b0;
         o_fuse_1 <= '0;
         o_fuse_2 <= '0;
      end
      else
      begin
         o_valid <= i_send;
         if (i_send)
         begin
            o_pu     <= i_pu;
            o_amp    <= i_pu + 13'h0001; // amperes differ from per-unit on purpose
            o_side   <= i_side;
            o_fuse_1 <= i_side ? 6'h00 : i_fuse;
            o_fuse_2 <= i_side ? i_fuse : 6'h00;
         end
      end
   end
endmodule : cbu_meas_model

/* test_cbu_stage.sv */
/*
 * Self-checking bench for the unbalance stage with the measurement model.
 * Assumes a shortened tick of TK cycles; all delays set in ticks.
 */
module test_cbu_stage;
   timeunit 1ns;
   timeprecision 1ps;
   import cbu_pkg::*;
   localparam int TK = 4;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, send = 1'b0, side = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0, o_rdata, d;
   logic [CUR_W-1:0] pu = '0, m_pu, m_amp;
   logic [FUSE_W-1:0] fuse = '0, f1, f2;
   logic m_valid, m_side, o_start, o_alarm, o_trip, o_irq;
   logic [1:0] o_state;
   int errors = 0, check_count = 0, n;

   cbu_meas_model cbu_meas_model_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_send(send), .i_pu(pu),
      .i_side(side), .i_fuse(fuse), .o_valid(m_valid), .o_pu(m_pu), .o_amp(m_amp),
      .o_side(m_side), .o_fuse_1(f1), .o_fuse_2(f2));
   cbu_stage #(.TICK_CYC(TK)) cbu_stage_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_meas_valid(m_valid), .i_unb_pu(m_pu),
      .i_unb_amp(m_amp), .i_unb_side(m_side), .i_fuse_cnt_1(f1), .i_fuse_cnt_2(f2),
      .o_rdata(o_rdata), .o_start(o_start), .o_alarm(o_alarm), .o_trip(o_trip),
      .o_state(o_state), .o_irq(o_irq));

   initial
   begin
      forever #5 i_clk = ~i_clk;
   end

   task automatic close_out();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask : rd

   task automatic meas(input logic [CUR_W-1:0] p, input logic s, input logic [FUSE_W-1:0] f);
      @(posedge i_clk);
      send <= 1'b1;
      pu <= p;
      side <= s;
      fuse <= f;
      @(posedge i_clk);
      send <= 1'b0;
   endtask : meas

   // bounded wait for a level; sel 0 start, 1 alarm, 2 trip, 3 irq
   task automatic wait_lvl(input int sel, input logic lvl, input int bnd);
      logic v;
      for (n = 0; n < bnd; n++)
      begin
         @(posedge i_clk);
         #1 v = (sel == 0) ? o_start : (sel == 1) ? o_alarm : (sel == 2) ? o_trip : o_irq;
         if (v === lvl)
            return;
      end
      errors++;
      $display("[ERR] t=%0t wait sel=%h lvl=%h", $time, sel, lvl);
      close_out();
   endtask : wait_lvl

   task automatic defaults_scn();
      logic [7:0]  a[8] = '{A_CTRL, A_ALM_THR, A_ALM_THR2, A_TRP_THR, A_TRP_THR2, A_FUSE_THR,
                            A_ALM_DLY, 8'h48};
      logic [31:0] e[8] = '{32'h1, 32'hA, 32'hA, 32'h14, 32'h14, 32'h05050303, 32'h3E8, 32'h0};
      for (int k = 0; k < 8; k++)
      begin
         rd(a[k], d);
         chk(d, e[k]);
      end
      rd(A_ALM_DLY2, d);
      chk(d, 32'h3E8);
      rd(A_STATUS, d);
      chk(d, 32'h0);
   endtask : defaults_scn

   task automatic alarm_scn();
      wr(A_ALM_DLY, 32'h3);
      meas(13'h000F, 1'b0, 6'h00);
      wait_lvl(0, 1'b1, 10);
      rd(A_ALM_REM, d);
      chk(d > 0 && d <= 3, 1'b1);
      wait_lvl(1, 1'b1, 20);
      chk(n + 4 >= 2 * TK && n <= 3 * TK + 4, 1'b1);
      rd(A_RATIO_ALM, d);
      chk(d, 32'd150);
      rd(A_MEAS_AMP, d);
      chk(d, 32'h10);
      meas(13'h000A, 1'b0, 6'h00);
      repeat (6) @(posedge i_clk);
      #1 chk(o_alarm, 1'b1);
      meas(13'h0009, 1'b0, 6'h00);
      wait_lvl(1, 1'b0, 5);
      chk(o_state, ST_NORMAL);
      // idle: expected time is the full alarm delay of side 1
      rd(A_EXP_ALM, d);
      chk(d, 32'h3);
   endtask : alarm_scn

   task automatic trip_scn();
      logic [31:0] r1;
      wr(A_TRP_DLY, 32'h6);
      meas(13'h0019, 1'b0, 6'h00);
      wait_lvl(0, 1'b1, 10);
      rd(A_TRP_REM, r1);
      repeat (TK + 2) @(posedge i_clk);
      rd(A_TRP_REM, d);
      chk(r1 > d && d > 0, 1'b1);
      rd(A_RATIO_TRP, d);
      chk(d, 32'd125);
      wait_lvl(2, 1'b1, 40);
      rd(A_STATUS, d);
      chk(d & 32'h3, ST_TRIPPED);
      meas(13'h0000, 1'b0, 6'h00);
      wait_lvl(2, 1'b0, 5);
   endtask : trip_scn

   task automatic side2_scn();
      wr(A_CTRL, 32'h3);
      wr(A_ALM_THR2, 32'h1E);
      wr(A_TRP_THR2, 32'h28);
      // above both side 1 thresholds, below both side 2 thresholds
      meas(13'h001C, 1'b1, 6'h00);
      repeat (8) @(posedge i_clk);
      #1 chk(o_start, 1'b0);
      rd(A_RATIO_TRP, d);
      chk(d, 32'd70);
      meas(13'h0014, 1'b1, 6'h00);
      wr(A_CTRL, 32'h1);
      wait_lvl(0, 1'b1, 10);
      meas(13'h0000, 1'b1, 6'h00);
      wait_lvl(0, 1'b0, 10);
   endtask : side2_scn

   task automatic fuse_scn();
      wr(A_CTRL, 32'h5);
      meas(13'h0000, 1'b0, 6'h03);
      wait_lvl(0, 1'b1, 10);
      wr(A_CTRL, 32'h1);
      meas(13'h0000, 1'b0, 6'h03);
      wait_lvl(0, 1'b0, 10);
   endtask : fuse_scn

   task automatic block_scn();
      rd(A_IRQ_STAT, d);
      chk(o_irq, 1'b0);
      wr(A_IRQ_MASK, 32'h1F);
      wr(A_CTRL, 32'h9);
      wait_lvl(3, 1'b1, 6);
      chk(o_state, ST_BLOCKED);
      rd(A_IRQ_STAT, d);
      chk(d, 32'h10);
      wait_lvl(3, 1'b0, 3);
      wr(A_CTRL, 32'h0);
      repeat (4) @(posedge i_clk);
      #1 chk(o_state, ST_NORMAL);
   endtask : block_scn

   initial
   begin
      repeat (16) @(posedge i_clk);
      i_nrst <= 1'b1;
      defaults_scn();
      alarm_scn();
      trip_scn();
      side2_scn();
      fuse_scn();
      block_scn();
      close_out();
   end
endmodule : test_cbu_stage
